/* reset_merge_pkg.sv */
// package: constants shared by the reset merge and synchroniser block
// assumes nothing beyond a SystemVerilog compiler
package reset_merge_pkg;

  // --------------------------------------------------------------------
  // synchroniser depth and levels
  // --------------------------------------------------------------------
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic RESET_LEVEL_N = 1'b0;
  localparam logic RUN_LEVEL_N = 1'b1;
  localparam logic [SYNC_STAGES-1:0] CHAIN_CLEAR = {SYNC_STAGES{RESET_LEVEL_N}};
  localparam logic [SYNC_STAGES-1:0] CHAIN_FILL = {SYNC_STAGES{RUN_LEVEL_N}};

  // --------------------------------------------------------------------
  // build option default
  // --------------------------------------------------------------------
  localparam logic RESET_CONTROL_DEFAULT = 1'b1;

endpackage : reset_merge_pkg

/* processor_reset_merge_sync.sv */
// file: reset merge and release synchroniser for a soft processor core
// assumes: sys_clk 200 MHz bus clock; all pins but reset synchronous to sys_clk;
// test_clk is a slow test clock seen here as an ordinary sampled input
`timescale 1ns/1ps

module processor_reset_merge_sync #(
  parameter logic RESET_CONTROL = reset_merge_pkg::RESET_CONTROL_DEFAULT // merge logic built
) (
  input wire logic sys_clk, // bus clock, 200 MHz
  input wire logic reset, // block reset, async, active high
  input wire logic main_system_reset_n, // main system reset request
  input wire logic auxiliary_reset_n, // additional reset request, any source
  input wire logic watchdog_bark_in, // watchdog bark, low requests reset
  input wire logic test_clk, // test clock, sampled as a level
  input wire logic test_reset_n, // test reset for debug port logic
  output logic processor_reset_n, // merged reset to the processor
  output logic ahb_reset_n, // exported bus reset for other components
  output logic watchdog_reset_out_n, // reset to the attached watchdog
  output logic debug_reset_n // reset for debug port logic
);

  // --------------------------------------------------------------------
  // reset requests
  // --------------------------------------------------------------------
  logic merged_request;
  logic system_clear;
  logic watchdog_clear;
  logic debug_clear;

  // bark is active low: while it is held low it asks for a reset
  always_comb begin
    merged_request = ~main_system_reset_n;
    if (RESET_CONTROL) begin
      merged_request = ~main_system_reset_n | ~auxiliary_reset_n
                       | ~watchdog_bark_in;
    end
  end

  // any request clears its chain at once, no clock needed
  assign system_clear = reset | merged_request;
  assign watchdog_clear = reset | ~main_system_reset_n;
  assign debug_clear = reset | ~test_reset_n;

  // --------------------------------------------------------------------
  // test clock edge detect
  // --------------------------------------------------------------------
  logic test_clk_now;
  logic test_clk_before;
  logic test_clk_rise;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      test_clk_now <= 1'b0;
      test_clk_before <= 1'b0;
    end else begin
      test_clk_now <= test_clk;
      test_clk_before <= test_clk_now;
    end
  end

  // one-cycle enable per rising test clock edge
  assign test_clk_rise = test_clk_now & ~test_clk_before;

  // --------------------------------------------------------------------
  // release chains
  // --------------------------------------------------------------------
  logic [reset_merge_pkg::SYNC_STAGES-1:0] system_chain;
  logic [reset_merge_pkg::SYNC_STAGES-1:0] watchdog_chain;
  logic [reset_merge_pkg::SYNC_STAGES-1:0] debug_chain;

  // the processor and bus share one chain so they leave reset together
  always_ff @(posedge sys_clk or posedge system_clear) begin
    if (system_clear) begin
      system_chain <= reset_merge_pkg::CHAIN_CLEAR;
    end else begin
      system_chain <= {system_chain[reset_merge_pkg::SYNC_STAGES-2:0],
                       reset_merge_pkg::RUN_LEVEL_N};
    end
  end

  // kept off the bark path so a bark never resets the watchdog itself
  always_ff @(posedge sys_clk or posedge watchdog_clear) begin
    if (watchdog_clear) begin
      watchdog_chain <= reset_merge_pkg::CHAIN_CLEAR;
    end else begin
      watchdog_chain <= {watchdog_chain[reset_merge_pkg::SYNC_STAGES-2:0],
                         reset_merge_pkg::RUN_LEVEL_N};
    end
  end

  // debug chain only steps on test clock edges; system resets do not touch it
  always_ff @(posedge sys_clk or posedge debug_clear) begin
    if (debug_clear) begin
      debug_chain <= reset_merge_pkg::CHAIN_CLEAR;
    end else if (test_clk_rise) begin
      debug_chain <= {debug_chain[reset_merge_pkg::SYNC_STAGES-2:0],
                      reset_merge_pkg::RUN_LEVEL_N};
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  // outputs are the chain ends themselves, so they stay glitch free
  assign processor_reset_n = system_chain[reset_merge_pkg::SYNC_STAGES-1];
  assign debug_reset_n = debug_chain[reset_merge_pkg::SYNC_STAGES-1];

  // without the merge logic these outputs are unused and parked inactive
  generate
    if (RESET_CONTROL) begin : g_control
      assign ahb_reset_n = system_chain[reset_merge_pkg::SYNC_STAGES-1];
      assign watchdog_reset_out_n =
        watchdog_chain[reset_merge_pkg::SYNC_STAGES-1];
    end else begin : g_no_control
      logic parked;
      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          parked <= reset_merge_pkg::RUN_LEVEL_N;
        end else begin
          parked <= reset_merge_pkg::RUN_LEVEL_N;
        end
      end
      assign ahb_reset_n = parked;
      assign watchdog_reset_out_n = parked;
    end
  endgenerate

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  main_assert_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    !main_system_reset_n |-> !processor_reset_n)
    else $error("main reset did not hold the processor in reset");

  aux_assert_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (RESET_CONTROL && !auxiliary_reset_n) |-> !processor_reset_n && !ahb_reset_n)
    else $error("auxiliary reset did not hold the system in reset");

  bark_assert_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (RESET_CONTROL && !watchdog_bark_in) |-> !processor_reset_n)
    else $error("low bark did not reset the processor");

  bark_high_release_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (!merged_request && watchdog_bark_in)[*3] |-> processor_reset_n)
    else $error("processor still in reset with bark high and no request");

  release_two_flops_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    $rose(processor_reset_n) |-> !$past(merged_request) && !$past(merged_request, 2))
    else $error("processor reset released sooner than two quiet cycles");

  bus_matches_cpu_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    RESET_CONTROL |-> (ahb_reset_n == processor_reset_n))
    else $error("exported bus reset differs from processor reset");

  unused_parked_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    !RESET_CONTROL |-> ahb_reset_n && watchdog_reset_out_n)
    else $error("unused reset outputs not parked inactive");

  watchdog_main_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (RESET_CONTROL && !main_system_reset_n) |-> !watchdog_reset_out_n)
    else $error("main reset did not reset the watchdog");

  watchdog_no_bark_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (RESET_CONTROL && main_system_reset_n)[*3] |-> watchdog_reset_out_n)
    else $error("watchdog reset followed something other than main reset");

  debug_reset_hold_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    !test_reset_n |-> !debug_reset_n)
    else $error("test reset did not hold debug logic in reset");

  debug_release_edge_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    $rose(debug_reset_n) |-> $past(test_clk_rise) && $past(test_reset_n))
    else $error("debug reset released off a test clock edge");

  // --------------------------------------------------------------------
  // release and isolation checks
  // --------------------------------------------------------------------
  // system requests must never move the debug chain between test clock edges
  debug_holds_steady_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (!test_clk_rise && test_reset_n) ##1 test_reset_n |-> $stable(debug_reset_n))
    else $error("debug reset moved without a test clock edge");

  debug_release_quiet_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    $rose(debug_reset_n) |-> $past(test_reset_n) && $past(test_reset_n, 2))
    else $error("debug reset released too soon after test reset");

  watchdog_release_quiet_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    $rose(watchdog_reset_out_n) |->
      $past(main_system_reset_n) && $past(main_system_reset_n, 2))
    else $error("watchdog reset released too soon after main reset");

  aux_release_waits_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (RESET_CONTROL && $rose(auxiliary_reset_n)) |-> !processor_reset_n)
    else $error("processor reset released on the same edge as aux");

  bare_main_only_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (!RESET_CONTROL && main_system_reset_n)[*3] |-> processor_reset_n)
    else $error("bare build held the processor in reset without main reset");

endmodule : processor_reset_merge_sync

/* watchdog_model.sv */
// watchdog partner: barks on command, idles while its reset is held
// assumes bench drives bite off the clock edge
`timescale 1ns/1ps

module watchdog_model (
  input wire logic watchdog_reset_out_n, // reset from the block
  input wire logic bite, // bench command to bark
  output logic watchdog_bark_in // bark, low asks for reset
);
  // a watchdog held in reset never barks
  assign watchdog_bark_in = !watchdog_reset_out_n ? 1'b1 : !bite;
endmodule : watchdog_model

/* processor_reset_merge_sync_test.sv */
// bench for the reset merge block with a watchdog partner
// assumes 200 MHz sys_clk and slow test clock made here
`timescale 1ns/1ps

module processor_reset_merge_sync_test;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic main_n = 1'b1;
  logic aux_n = 1'b1;
  logic bite = 1'b0;
  logic test_clk = 1'b0;
  logic test_reset_n = 1'b1;
  logic bark, proc_n, ahb_n, wdo_n, dbg_n;
  logic nc_proc, nc_ahb, nc_wdo, nc_dbg;
  int fail_count = 0;
  int total_checks = 0;

  always #2.5 sys_clk = ~sys_clk;

  processor_reset_merge_sync processor_reset_merge_sync_inst (
    .sys_clk(sys_clk), .reset(reset), .main_system_reset_n(main_n),
    .auxiliary_reset_n(aux_n), .watchdog_bark_in(bark), .test_clk(test_clk),
    .test_reset_n(test_reset_n), .processor_reset_n(proc_n), .ahb_reset_n(ahb_n),
    .watchdog_reset_out_n(wdo_n), .debug_reset_n(dbg_n));

  // second build without reset control, sharing all stimulus
  if (1) begin : no_control
    processor_reset_merge_sync #(
      .RESET_CONTROL(1'b0)
    ) processor_reset_merge_sync_inst (
      .sys_clk(sys_clk), .reset(reset), .main_system_reset_n(main_n),
      .auxiliary_reset_n(aux_n), .watchdog_bark_in(bark), .test_clk(test_clk),
      .test_reset_n(test_reset_n), .processor_reset_n(nc_proc), .ahb_reset_n(nc_ahb),
      .watchdog_reset_out_n(nc_wdo), .debug_reset_n(nc_dbg));
  end

  watchdog_model watchdog_model_inst (
    .watchdog_reset_out_n(wdo_n), .bite(bite), .watchdog_bark_in(bark));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %b expected %b", $time, got, exp);
    end
  endtask : chk

  task step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step

  task sys_all(input logic p, input logic w);
    chk(proc_n, p);
    chk(ahb_n, p);
    chk(wdo_n, w);
    chk(dbg_n, 1'b1);
  endtask : sys_all

  task test_tick;
    @(posedge sys_clk) test_clk <= 1'b1;
    step(4);
    test_clk <= 1'b0;
    step(4);
  endtask : test_tick

  task test_done;
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task debug_path;
    @(posedge sys_clk) test_reset_n <= 1'b0;
    #1 chk(dbg_n, 1'b0);
    step(2);
    test_reset_n <= 1'b1;
    step(10);
    chk(dbg_n, 1'b0);
    test_tick();
    chk(dbg_n, 1'b0);
    test_tick();
    test_tick();
    chk(dbg_n, 1'b1);
  endtask : debug_path

  task main_path;
    @(posedge sys_clk) main_n <= 1'b0;
    #1 sys_all(1'b0, 1'b0);
    chk(nc_proc, 1'b0);
    chk(nc_wdo, 1'b1);
    step(3);
    main_n <= 1'b1;
    step(1);
    sys_all(1'b0, 1'b0);
    step(1);
    sys_all(1'b1, 1'b1);
  endtask : main_path

  task aux_path;
    @(posedge sys_clk) aux_n <= 1'b0;
    #1 sys_all(1'b0, 1'b1);
    chk(nc_proc, 1'b1);
    chk(nc_ahb, 1'b1);
    step(3);
    aux_n <= 1'b1;
    step(1);
    chk(proc_n, 1'b0);
    step(1);
    sys_all(1'b1, 1'b1);
  endtask : aux_path

  task bark_path;
    step(5);
    sys_all(1'b1, 1'b1);
    @(posedge sys_clk) bite <= 1'b1;
    #1 sys_all(1'b0, 1'b1);
    chk(nc_proc, 1'b1);
    chk(nc_dbg, 1'b1);
    step(3);
    bite <= 1'b0;
    step(2);
    sys_all(1'b1, 1'b1);
  endtask : bark_path

  initial begin
    step(12);
    reset <= 1'b0;
    debug_path();
    main_path();
    aux_path();
    bark_path();
    test_done();
  end

  initial begin
    #5000;
    fail_count++;
    test_done();
  end
endmodule : processor_reset_merge_sync_test
